// ===== core/csg_pkg.sv
package csg_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [21:0] CSG_IDX_RX_ACC    = 22'h1F0010;
    localparam logic [21:0] CSG_IDX_RX_DROP   = 22'h1F0011;
    localparam logic [21:0] CSG_IDX_TX_ACC    = 22'h1F0012;
    localparam logic [21:0] CSG_IDX_TX_DROP   = 22'h1F0013;
    localparam logic [21:0] CSG_IDX_GRP_CFG   = 22'h1F0014;
    localparam logic [21:0] CSG_IDX_GRP_STATE = 22'h1F0015;
    localparam logic [21:0] CSG_IDX_CTRL      = 22'h1F0020;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int CSG_CNT_W      = 24;
    localparam int CSG_DEPTH_W    = 15;
    localparam int CSG_CODE_W     = 4;
    localparam int CSG_MAX_LSB    = 12;
    localparam int CSG_CONG_LSB   = 8;
    localparam int CSG_MAXED_BIT  = 19;
    localparam int CSG_NEAR_BIT   = 18;
    localparam int CSG_OVER_BIT   = 17;
    localparam int CSG_CONGF_BIT  = 16;
    localparam int CSG_RSVD_BIT   = 15;
    localparam int CSG_CTL_SOFT   = 0;
    localparam int CSG_CTL_EN     = 1;
    localparam int CSG_CTL_HYST   = 2;
    localparam int CSG_CTL_ALT    = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CSG_CNT_W-1:0]   CSG_CNT_RST   = 24'h000000;
    localparam logic [7:0]             CSG_CFG_RST   = 8'h00;
    localparam logic [CSG_DEPTH_W-1:0] CSG_DEPTH_RST = 15'h0000;
    localparam logic [3:0]             CSG_CTRL_RST  = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rx_accept;
        logic rx_drop;
        logic tx_accept;
        logic tx_drop;
    } csg_cell_evt_t;

    typedef struct packed {
        logic maxed;
        logic near;
        logic over;
        logic congested;
    } csg_flags_t;

endpackage

// ===== core/csg_regs.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// How it works
// - Receive accepted cells counted in a 24-bit wrapping counter, bits 23:0.
// - Receive discarded cells counted in a 24-bit wrapping counter, bits 23:0.
// - Transmit accepted cells counted in a 24-bit wrapping counter, bits 23:0.
// - Transmit discarded cells counted in a 24-bit wrapping counter, bits 23:0.
// - All four counters held at zero while soft or hard reset is high.
// - Counter registers are read-only; host writes leave them unchanged.
// - Config bits 15:12 hold the group maximum depth code.
// - Config bits 11:8 hold the group congestion depth code.
// - Group limits act only while the group-limit enable is set.
// - State bit 19 shows maximum congestion; read-only, resets to zero.
// - State bit 18 shows depth above the threshold one code lower.
// - State bit 17 shows depth above the congestion threshold.
// - State bit 16 shows congestion using code, hysteresis and encoding settings.
// - State bits 14:0 hold group depth, reset zero; host zeroes it in soft reset.
module csg_regs
    import csg_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [23:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   hard_reset_ctl,
    input  wire csg_cell_evt_t          cell_evt,
    input  wire logic                   grp_enqueue,
    input  wire logic                   grp_dequeue,
    output logic                        grp_drop_req,
    output logic                        grp_congested_out
);

    // ------------------------------------------------------------
    // Threshold decoding
    // ------------------------------------------------------------
    function automatic logic [CSG_DEPTH_W-1:0] depth_of(
        input logic [CSG_CODE_W-1:0] code,
        input logic                  alt
    );
        logic [CSG_DEPTH_W:0] v;
        v = '0;
        if (alt)
            v = ({12'h000, 4'h2} | {15'h0000, code[0]}) << code[3:1];
        else
            v = 16'h0001 << code;
        if (v[CSG_DEPTH_W])
            depth_of = '1;
        else
            depth_of = v[CSG_DEPTH_W-1:0];
    endfunction

    function automatic logic [CSG_CODE_W-1:0] code_less(
        input logic [CSG_CODE_W-1:0] code
    );
        code_less = (code == 4'h0) ? 4'h0 : code - 4'h1;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CSG_CNT_W-1:0]   rx_accepted_count_reg;
    logic [CSG_CNT_W-1:0]   rx_discarded_count_reg;
    logic [CSG_CNT_W-1:0]   tx_accepted_count_reg;
    logic [CSG_CNT_W-1:0]   tx_discarded_count_reg;
    logic [3:0]             grp_max_depth_code_reg;
    logic [3:0]             grp_cong_depth_code_reg;
    logic [CSG_DEPTH_W-1:0] grp_current_depth_reg;
    logic [CSG_DEPTH_W-1:0] grp_current_depth_next;
    logic                   state_rsvd_reg;
    logic [3:0]             ctrl_reg;
    csg_flags_t             flags_reg;
    csg_flags_t             flags_next;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic [21:0] word_idx    = paddr[23:2];
    wire logic        setup_ph    = psel & ~penable;
    wire logic        access_ph   = psel & penable;
    wire logic        wr_en       = access_ph & pwrite;
    wire logic        hit_rx_acc  = (word_idx == CSG_IDX_RX_ACC);
    wire logic        hit_rx_drop = (word_idx == CSG_IDX_RX_DROP);
    wire logic        hit_tx_acc  = (word_idx == CSG_IDX_TX_ACC);
    wire logic        hit_tx_drop = (word_idx == CSG_IDX_TX_DROP);
    wire logic        hit_cfg     = (word_idx == CSG_IDX_GRP_CFG);
    wire logic        hit_state   = (word_idx == CSG_IDX_GRP_STATE);
    wire logic        hit_ctrl    = (word_idx == CSG_IDX_CTRL);
    wire logic        hit_any     = hit_rx_acc | hit_rx_drop | hit_tx_acc | hit_tx_drop
                                    | hit_cfg | hit_state | hit_ctrl;
    wire logic        misaligned  = |paddr[1:0];
    wire logic        bad_addr    = ~hit_any | misaligned;

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    wire logic soft_reset_ctl      = ctrl_reg[CSG_CTL_SOFT];
    wire logic rx_group_limit_en   = ctrl_reg[CSG_CTL_EN];
    wire logic rx_hyst_off         = ctrl_reg[CSG_CTL_HYST];
    wire logic rx_alt_depth_coding = ctrl_reg[CSG_CTL_ALT];
    wire logic cnt_clear           = soft_reset_ctl | hard_reset_ctl;

    // ------------------------------------------------------------
    // Group thresholds and flags
    // ------------------------------------------------------------
    wire logic [CSG_DEPTH_W-1:0] grp_max_depth =
        depth_of(grp_max_depth_code_reg, rx_alt_depth_coding);
    wire logic [CSG_DEPTH_W-1:0] grp_cong_threshold =
        depth_of(grp_cong_depth_code_reg, rx_alt_depth_coding);
    wire logic [CSG_DEPTH_W-1:0] grp_near_depth =
        depth_of(code_less(grp_cong_depth_code_reg), rx_alt_depth_coding);
    wire logic [CSG_DEPTH_W-1:0] grp_exit_depth =
        rx_hyst_off ? grp_cong_threshold : {1'b0, grp_cong_threshold[CSG_DEPTH_W-1:1]};

    wire logic d_maxed = grp_current_depth_next >= grp_max_depth;
    wire logic d_over  = grp_current_depth_next > grp_cong_threshold;
    wire logic d_near  = grp_current_depth_next > grp_near_depth;
    wire logic d_exit  = grp_current_depth_next <= grp_exit_depth;

    always_comb
    begin
        flags_next = '0;
        if (rx_group_limit_en)
        begin
            flags_next.maxed     = d_maxed;
            flags_next.near      = d_near;
            flags_next.over      = d_over;
            flags_next.congested = d_over | (flags_reg.congested & ~d_exit);
        end
    end

    // ------------------------------------------------------------
    // Group depth tracking
    // ------------------------------------------------------------
    wire logic depth_wr  = wr_en & hit_state & ~misaligned;
    wire logic depth_inc = grp_enqueue & ~grp_dequeue & ~(&grp_current_depth_reg);
    wire logic depth_dec = grp_dequeue & ~grp_enqueue & (|grp_current_depth_reg);

    always_comb
    begin
        grp_current_depth_next = grp_current_depth_reg;
        if (depth_wr)
            grp_current_depth_next = pwdata[CSG_DEPTH_W-1:0];
        else if (depth_inc)
            grp_current_depth_next = grp_current_depth_reg + 15'h0001;
        else if (depth_dec)
            grp_current_depth_next = grp_current_depth_reg - 15'h0001;
    end

    assign grp_drop_req      = flags_reg.maxed;
    assign grp_congested_out = flags_reg.congested;

    // ------------------------------------------------------------
    // Cell counters
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_accepted_count_reg  <= CSG_CNT_RST;
            rx_discarded_count_reg <= CSG_CNT_RST;
            tx_accepted_count_reg  <= CSG_CNT_RST;
            tx_discarded_count_reg <= CSG_CNT_RST;
        end
        else if (cnt_clear)
        begin
            rx_accepted_count_reg  <= CSG_CNT_RST;
            rx_discarded_count_reg <= CSG_CNT_RST;
            tx_accepted_count_reg  <= CSG_CNT_RST;
            tx_discarded_count_reg <= CSG_CNT_RST;
        end
        else
        begin
            rx_accepted_count_reg  <= rx_accepted_count_reg + {23'h0, cell_evt.rx_accept};
            rx_discarded_count_reg <= rx_discarded_count_reg + {23'h0, cell_evt.rx_drop};
            tx_accepted_count_reg  <= tx_accepted_count_reg + {23'h0, cell_evt.tx_accept};
            tx_discarded_count_reg <= tx_discarded_count_reg + {23'h0, cell_evt.tx_drop};
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_max_depth_code_reg  <= CSG_CFG_RST[3:0];
            grp_cong_depth_code_reg <= CSG_CFG_RST[7:4];
            ctrl_reg                <= CSG_CTRL_RST;
            state_rsvd_reg          <= 1'b0;
        end
        else if (wr_en && !misaligned)
        begin
            if (hit_cfg)
            begin
                grp_max_depth_code_reg  <= pwdata[CSG_MAX_LSB +: CSG_CODE_W];
                grp_cong_depth_code_reg <= pwdata[CSG_CONG_LSB +: CSG_CODE_W];
            end
            if (hit_state)
                state_rsvd_reg <= pwdata[CSG_RSVD_BIT];
            if (hit_ctrl)
                ctrl_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_current_depth_reg <= CSG_DEPTH_RST;
            flags_reg             <= '0;
        end
        else
        begin
            grp_current_depth_reg <= grp_current_depth_next;
            flags_reg             <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    wire logic [31:0] state_word = {12'h000, flags_reg.maxed, flags_reg.near, flags_reg.over,
                                    flags_reg.congested, state_rsvd_reg, grp_current_depth_reg};
    wire logic [31:0] cfg_word   = {16'h0000, grp_max_depth_code_reg, grp_cong_depth_code_reg,
                                    8'h00};
    wire logic [31:0] rd_mux     =
        ({32{hit_rx_acc}}  & {8'h00, rx_accepted_count_reg})  |
        ({32{hit_rx_drop}} & {8'h00, rx_discarded_count_reg}) |
        ({32{hit_tx_acc}}  & {8'h00, tx_accepted_count_reg})  |
        ({32{hit_tx_drop}} & {8'h00, tx_discarded_count_reg}) |
        ({32{hit_cfg}}     & cfg_word)                         |
        ({32{hit_state}}   & state_word)                       |
        ({32{hit_ctrl}}    & {28'h0000000, ctrl_reg});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_reg  <= (pwrite || bad_addr) ? 32'h00000000 : rd_mux;
            pslverr_reg <= bad_addr;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = access_ph & pslverr_reg;

endmodule

// ===== testbench/csg_regs_chk.sv
`timescale 1ns/1ps
module csg_regs_chk
    import csg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [23:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        hard_reset_ctl,
    input  wire logic        grp_drop_req,
    input  wire logic        grp_congested_out
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic [21:0] idx    = paddr[23:2];
    wire logic        rd_acc = psel && penable && !pwrite;
    wire logic        is_cnt = (idx >= CSG_IDX_RX_ACC) && (idx <= CSG_IDX_TX_DROP);
    wire logic        hit    = (paddr[1:0] == 2'h0) && ((idx >= CSG_IDX_RX_ACC
                               && idx <= CSG_IDX_GRP_STATE) || idx == CSG_IDX_CTRL);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    no_wait_a: assert property (psel && penable |-> pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    unmapped_err_a: assert property (psel && penable && !hit |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && penable && hit |-> !pslverr)
        else $error("mapped access refused");
    cnt_upper_a: assert property (rd_acc && is_cnt |-> prdata[31:24] == 8'h00)
        else $error("counter upper bits set");
    cfg_unused_a: assert property (rd_acc && idx == CSG_IDX_GRP_CFG
        |-> prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00) else $error("config spare bits");
    state_unused_a: assert property (rd_acc && idx == CSG_IDX_GRP_STATE
        |-> prdata[31:20] == 12'h000) else $error("state spare bits set");
    hard_clear_a: assert property (hard_reset_ctl && $past(hard_reset_ctl)
        && $past(hard_reset_ctl, 2) && rd_acc && is_cnt |-> prdata[23:0] == 24'h000000)
        else $error("counter not cleared by hard reset");
    reset_flags_a: assert property ($rose(presetn) |-> !grp_drop_req && !grp_congested_out)
        else $error("flags set after reset");
endmodule

bind csg_regs csg_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hard_reset_ctl(hard_reset_ctl), .grp_drop_req(grp_drop_req),
    .grp_congested_out(grp_congested_out));

// ===== testbench/csg_regs_tb_top.sv
`timescale 1ns/1ps
module csg_regs_tb_top
    import csg_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, hard_reset_ctl, erv;
    logic          pready, pslverr, grp_enqueue, grp_dequeue, grp_drop_req, grp_congested_out;
    logic [23:0]   paddr;
    logic [31:0]   pwdata, prdata, rdv;
    logic [31:0]   cnt [4] = '{32'h5, 32'h7, 32'h9, 32'h3};
    csg_cell_evt_t cell_evt;
    int            err_count, n_tests;

    csg_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hard_reset_ctl, .cell_evt, .grp_enqueue, .grp_dequeue,
        .grp_drop_req, .grp_congested_out);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [21:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [21:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(rdv, exp);
    endtask
    task automatic ev(input csg_cell_evt_t e, input int n);
        @(posedge pclk);
        cell_evt <= e;
        repeat (n) @(posedge pclk);
        cell_evt <= '0;
    endtask
    task automatic qd(input logic e, input logic d, input int n);
        @(posedge pclk);
        grp_enqueue <= e;
        grp_dequeue <= d;
        repeat (n) @(posedge pclk);
        grp_enqueue <= 1'b0;
        grp_dequeue <= 1'b0;
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #100us;
        err_count++;
        conclude();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, hard_reset_ctl, grp_enqueue, grp_dequeue} = '0;
        paddr = 24'h000000;
        pwdata = 32'h0;
        cell_evt = '0;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(CSG_IDX_RX_ACC + 22'(i), 32'h0);
        ev(4'h8, 3);
        ev(4'h4, 5);
        ev(4'h2, 7);
        ev(4'h1, 1);
        ev(4'hF, 2);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, CSG_IDX_RX_ACC + 22'(i), 32'hFF0000AA);
            rd(CSG_IDX_RX_ACC + 22'(i), cnt[i]);
        end
        xfer(1'b1, CSG_IDX_CTRL, 32'h1);
        xfer(1'b1, CSG_IDX_GRP_STATE, 32'h0);
        rd(CSG_IDX_GRP_STATE, 32'h0);
        ev(4'hF, 2);
        for (int i = 0; i < 4; i++)
            rd(CSG_IDX_RX_ACC + 22'(i), 32'h0);
        xfer(1'b1, CSG_IDX_CTRL, 32'h0);
        ev(4'h8, 1);
        rd(CSG_IDX_RX_ACC, 32'h1);
        @(posedge pclk);
        hard_reset_ctl <= 1'b1;
        ev(4'hF, 2);
        for (int i = 0; i < 4; i++)
            rd(CSG_IDX_RX_ACC + 22'(i), 32'h0);
        @(posedge pclk);
        hard_reset_ctl <= 1'b0;
        xfer(1'b1, CSG_IDX_GRP_CFG, 32'h00003200);
        rd(CSG_IDX_GRP_CFG, 32'h00003200);
        xfer(1'b1, CSG_IDX_GRP_STATE, 32'h5);
        rd(CSG_IDX_GRP_STATE, 32'h5);
        xfer(1'b1, CSG_IDX_CTRL, 32'h2);
        rd(CSG_IDX_GRP_STATE, 32'h00070005);
        qd(1'b1, 1'b0, 3);
        rd(CSG_IDX_GRP_STATE, 32'h000F0008);
        check(32'({grp_drop_req, grp_congested_out}), 32'h3);
        qd(1'b0, 1'b1, 5);
        rd(CSG_IDX_GRP_STATE, 32'h00050003);
        qd(1'b0, 1'b1, 1);
        rd(CSG_IDX_GRP_STATE, 32'h2);
        qd(1'b1, 1'b1, 4);
        rd(CSG_IDX_GRP_STATE, 32'h2);
        xfer(1'b1, CSG_IDX_CTRL, 32'h6);
        qd(1'b1, 1'b0, 3);
        rd(CSG_IDX_GRP_STATE, 32'h00070005);
        qd(1'b0, 1'b1, 1);
        rd(CSG_IDX_GRP_STATE, 32'h00040004);
        xfer(1'b1, CSG_IDX_GRP_CFG, 32'h00005300);
        xfer(1'b1, CSG_IDX_CTRL, 32'hA);
        qd(1'b1, 1'b0, 3);
        rd(CSG_IDX_GRP_STATE, 32'h00070007);
        xfer(1'b1, CSG_IDX_CTRL, 32'h0);
        rd(CSG_IDX_GRP_STATE, 32'h7);
        rd(CSG_IDX_CTRL, 32'h0);
        xfer(1'b0, CSG_IDX_CTRL + 22'h1, 32'h0);
        check(32'(erv), 32'h1);
        conclude();
    end
endmodule
